// ---- hdl/rmr_pkg.sv ----
// Package for the reset mode and software reset controller.
// Assumes a 10 MHz system clock and a serial command deserialiser elsewhere.
package rmr_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int SW_RST_US = 250;
  localparam int SW_RST_CYC = SW_RST_US * (CLK_HZ / 1_000_000);
  localparam int POR_MS = 100;
  localparam int POR_CYC = POR_MS * (CLK_HZ / 1000);

  // ------------------------------------------------------------
  // Commands
  // ------------------------------------------------------------
  localparam int CMD_W = 16;
  localparam logic [15:0] CMD_SW_RESET = 16'hfe00;
  localparam logic [7:0] CMD_FIFO_MODE_HI = 8'hca;
  localparam int MODE_BIT = 0;

  typedef enum logic {
    RMR_SENSITIVE,
    RMR_NORMAL
  } rmr_mode_e;

  typedef enum logic [1:0] {
    RMR_ST_POR,
    RMR_ST_SW,
    RMR_ST_RUN
  } rmr_state_e;

  // Analog supply comparator results
  typedef struct packed {
    logic rise_fast;
    logic ramp_diff;
    logic below_sens;
    logic below_norm;
  } rmr_supply_s;

endpackage

// ---- hdl/rmr_ctrl.sv ----
// Reset mode selection, supply glitch reset and software reset decoding.
// Assumes supply comparators are synchronous inputs and the serial command
// word arrives complete with a one-cycle strobe at chip select release.
`timescale 1ns/1ps

module rmr_ctrl
  import rmr_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYC,
  parameter int SW_CYCLES = SW_RST_CYC
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire rmr_supply_s supply_i,
  input wire logic cmd_valid_i,
  input wire logic [CMD_W-1:0] cmd_word_i,
  output logic chip_rst_o,
  output logic normal_mode_o,
  output logic cmd_busy_o
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  rmr_state_e state;
  rmr_mode_e mode;
  logic [31:0] cnt;
  logic glitch_hit;
  logic fall_hit;
  logic cmd_ok;

  // Glitch path is gated off entirely in normal mode
  assign glitch_hit = (mode == RMR_SENSITIVE) && supply_i.rise_fast
    && supply_i.ramp_diff;
  assign fall_hit = (mode == RMR_SENSITIVE) ? supply_i.below_sens
    : supply_i.below_norm;
  // Strobe only comes after full word and deselect
  assign cmd_ok = cmd_valid_i && (state == RMR_ST_RUN);

  // ------------------------------------------------------------
  // Reset sequencing
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || glitch_hit || fall_hit)
    begin
      state <= RMR_ST_POR;
      cnt <= 32'h0;
    end
    else
    begin
      unique case (state)
        RMR_ST_POR:
        begin
          if (cnt >= 32'(POR_CYCLES - 1))
          begin
            state <= RMR_ST_RUN;
            cnt <= 32'h0;
          end
          else
            cnt <= cnt + 32'h1;
        end
        RMR_ST_SW:
        begin
          if (cnt >= 32'(SW_CYCLES - 1))
          begin
            state <= RMR_ST_RUN;
            cnt <= 32'h0;
          end
          else
            cnt <= cnt + 32'h1;
        end
        RMR_ST_RUN:
        begin
          if (cmd_ok && cmd_word_i == CMD_SW_RESET
              && mode == RMR_SENSITIVE)
          begin
            state <= RMR_ST_SW;
            cnt <= 32'h0;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Reset mode register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || state != RMR_ST_RUN)
      mode <= RMR_SENSITIVE;
    else if (cmd_ok && cmd_word_i[15:8] == CMD_FIFO_MODE_HI
             && cmd_word_i[MODE_BIT])
      mode <= RMR_NORMAL;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      chip_rst_o <= 1'b1;
      normal_mode_o <= 1'b0;
      cmd_busy_o <= 1'b1;
    end
    else
    begin
      chip_rst_o <= (state != RMR_ST_RUN);
      normal_mode_o <= (mode == RMR_NORMAL);
      cmd_busy_o <= (state == RMR_ST_POR);
    end
  end

endmodule // rmr_ctrl

// ---- dv/rmr_host.sv ----
// Host model: one command word per send
// Assumes the word is taken at the next rising edge
`timescale 1ns/1ps
module rmr_host
(
  input wire logic clk_i,
  output logic v_o = 0,
  output logic [15:0] d_o = 16'h0
);
  task send(input logic [15:0] w);
    @(negedge clk_i);
    v_o = 1;
    d_o = w;
    @(negedge clk_i);
    v_o = 0;
    d_o = ~w; // Released bus shows no stale word
  endtask
endmodule // rmr_host

// ---- dv/rmr_ctrl_sva.sv ----
// Port checker for rmr_ctrl
// Assumes a quiet supply near commands
`timescale 1ns/1ps
module rmr_ctrl_sva
  import rmr_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire rmr_supply_s supply_i,
  input wire logic cmd_valid_i,
  input wire logic [CMD_W-1:0] cmd_word_i,
  input wire logic chip_rst_o,
  input wire logic normal_mode_o,
  input wire logic cmd_busy_o
);
  logic up, sw, mc, nm, sm;
  assign up = cmd_valid_i && !chip_rst_o;
  assign sw = up && cmd_word_i == CMD_SW_RESET;
  assign mc = up && cmd_word_i[15:8] == CMD_FIFO_MODE_HI && cmd_word_i[0];
  assign nm = normal_mode_o && !chip_rst_o;
  assign sm = !normal_mode_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_mode_default: assert property ($past(sys_rst_i) |-> sm)
    else $error("mode");
  a_mode_cmd: assert property (mc |-> ##2 normal_mode_o)
    else $error("mode cmd");
  a_sw_start: assert property (sw && sm |-> ##2 chip_rst_o)
    else $error("sw start");
  a_sw_refused: assert property (sw && nm |-> ##2 !chip_rst_o)
    else $error("sw refused");
  a_glitch_off: assert property (nm && supply_i == 4'hc
    |-> ##2 !chip_rst_o) else $error("glitch off");
  a_glitch_on: assert property (sm && supply_i[3:2] == 2'h3
    |-> ##[1:3] chip_rst_o) else $error("glitch on");
  a_fall_sens: assert property (sm && supply_i.below_sens
    |-> ##[1:3] chip_rst_o) else $error("fall sens");
  a_fall_norm: assert property (nm && supply_i.below_norm
    |-> ##[1:3] chip_rst_o) else $error("fall norm");
endmodule // rmr_ctrl_sva
bind rmr_ctrl rmr_ctrl_sva u_sva (.*);

// ---- dv/test_reset_mode_and_soft_reset.sv ----
// Bench for rmr_ctrl reset modes
// Counts shrunk to 50 and 20 cycles
`timescale 1ns/1ps
module test_reset_mode_and_soft_reset
  import rmr_pkg::*;
();
  logic clk_i = 0;
  logic sys_rst_i = 1;
  rmr_supply_s supply_i = '0;
  logic cmd_valid_i, chip_rst_o, normal_mode_o, cmd_busy_o;
  logic [CMD_W-1:0] cmd_word_i;
  int fails = 0;
  int n_checks = 0;
  always #50 clk_i = ~clk_i;
  rmr_host h (.clk_i, .v_o(cmd_valid_i), .d_o(cmd_word_i));
  rmr_ctrl #(.POR_CYCLES(50), .SW_CYCLES(20)) DUT (.*);
  task chk(input string n, input logic e, input logic s);
    n_checks++;
    if (s !== e)
    begin
      fails++;
      $display("Error %s expected %b seen %b", n, e, s);
    end
  endtask
  task ck(input string n, input logic e, input int c, input rmr_supply_s s);
    supply_i = s;
    repeat (c) @(negedge clk_i);
    supply_i = '0;
    repeat (2) @(negedge clk_i);
    chk(n, e, chip_rst_o);
  endtask
  task wt; // Bounded, power-on is 50
    for (int i = 0; i < 99 && chip_rst_o !== 0; i++) @(negedge clk_i);
  endtask
  task complete_run;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task t_sens;
    wt;
    chk("mode", 0, normal_mode_o);
    chk("busy", 0, cmd_busy_o);
    h.send(CMD_SW_RESET);
    ck("sw start", 1, 0, '0);
    ck("sw hold", 1, 16, '0);
    ck("sw end", 0, 2, '0);
    ck("glitch", 1, 1, 4'hc);
    chk("busy", 1, cmd_busy_o);
    wt;
    ck("fall", 1, 1, 4'h2);
    $display("sensitive test done");
  endtask
  task t_norm;
    wt;
    h.send(16'hca01);
    ck("mode set", 0, 0, '0);
    chk("mode set", 1, normal_mode_o);
    h.send(CMD_SW_RESET);
    ck("sw ignored", 0, 1, '0);
    ck("glitch off", 0, 2, 4'hc);
    ck("fall", 1, 1, 4'h1);
    wt;
    chk("mode back", 0, normal_mode_o);
    $display("normal test done");
  endtask
  initial
  begin
    repeat (2) @(negedge clk_i);
    sys_rst_i = 0;
    t_sens;
    t_norm;
    complete_run;
  end
  initial
  begin
    #200000;
    fails++;
    complete_run;
  end
endmodule // test_reset_mode_and_soft_reset
